// ### rtl/dsp_sec_top.sv
/*
 * Security password command logic: takes security commands and their
 * data sectors, keeps lock state and unlock counter, APB registers.
 * Assumes commands and sector words come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module dsp_sec_top
    import dsp_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_paddr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_code,
    output logic o_cmd_ready,
    input wire logic i_data_valid,
    input wire logic [15:0] i_data_word,
    output logic o_data_ready,
    output logic o_done,
    output logic o_abort,
    output logic o_erase_grant,
    output logic o_locked,
    output logic [15:0] o_id_word92,
    output logic o_taskfile_we,
    output logic o_irq
);
    typedef struct packed {
        dsp_state_t state;
        logic [7:0] opcode;
        logic [7:0] wcnt;
        logic ctl_ident;
        logic ctl_level;
        logic [15:0] rev_in;
        logic [15:0] rev;
        logic enabled;
        logic level;
        logic locked;
        logic frozen;
        logic prep;
        logic [2:0] cnt;
        logic done;
        logic abort;
        logic grant;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0] prdata;
    } dsp_top_t;

    dsp_top_t r_reg;
    dsp_top_t r_next;
    dsp_pw_if pw ();

    logic apb_setup;
    logic apb_access;
    logic apb_hit;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic hrst;
    logic freeze;
    logic in_pw;

    // ****************************************
    // password store
    // ****************************************
    dsp_pw_store u_store (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .pw(pw.store)
    );

    // ****************************************
    // apb decode
    // ****************************************
    assign apb_setup = i_psel && !i_penable;
    assign apb_access = i_psel && i_penable;
    always_comb begin
        case (i_paddr)
            OFS_CTRL, OFS_STATE, OFS_REV, OFS_IRQ_STAT, OFS_IRQ_MASK: apb_hit = 1'b1;
            default: apb_hit = 1'b0;
        endcase
    end
    assign hrst = apb_access && i_pwrite && (i_paddr == OFS_CTRL) && i_pwdata[CTRL_HRST_BIT];
    assign freeze = apb_access && i_pwrite && (i_paddr == OFS_CTRL)
        && i_pwdata[CTRL_FREEZE_BIT];
    // only the bits that the read returned are cleared
    assign clr = (apb_access && !i_pwrite && (i_paddr == OFS_IRQ_STAT))
        ? r_reg.prdata[IRQ_W-1:0] : IRQ_RESET;
    assign in_pw = (r_reg.wcnt >= WORD_PW_FIRST) && (r_reg.wcnt <= WORD_PW_LAST);

    // ****************************************
    // command sequencer
    // ****************************************
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.abort = 1'b0;
        r_next.grant = 1'b0;
        pw.start = 1'b0;
        pw.wr = 1'b0;
        pw.cmp = 1'b0;
        pw.sel_master = r_reg.ctl_ident;
        pw.idx = 4'(r_reg.wcnt - WORD_PW_FIRST);
        pw.word = i_data_word;
        case (r_reg.state)
            DSP_IDLE: begin
                if (i_cmd_valid) begin
                    r_next.opcode = i_cmd_code;
                    r_next.wcnt = WORD_CTL;
                    if (i_cmd_code != CMD_ERASE_PREP) begin
                        r_next.prep = 1'b0;
                    end
                    case (i_cmd_code)
                        CMD_SET_PW: begin
                            if (r_reg.frozen) begin
                                r_next.done = 1'b1;
                                r_next.abort = 1'b1;
                            end else begin
                                r_next.state = DSP_XFER;
                                pw.start = 1'b1;
                            end
                        end
                        CMD_UNLOCK: begin
                            if (r_reg.frozen || r_reg.cnt == '0) begin
                                r_next.done = 1'b1;
                                r_next.abort = 1'b1;
                            end else begin
                                r_next.state = DSP_XFER;
                                pw.start = 1'b1;
                            end
                        end
                        CMD_ERASE_PREP: begin
                            r_next.done = 1'b1;
                            r_next.abort = r_reg.frozen;
                            r_next.prep = !r_reg.frozen;
                        end
                        CMD_ERASE_UNIT: begin
                            r_next.done = 1'b1;
                            r_next.abort = r_reg.frozen || r_reg.cnt == '0 || !r_reg.prep;
                            r_next.grant = !(r_reg.frozen || r_reg.cnt == '0 || !r_reg.prep);
                        end
                        CMD_DISABLE_PW: begin
                            r_next.done = 1'b1;
                            r_next.abort = r_reg.frozen;
                            r_next.grant = !r_reg.frozen;
                        end
                        default: begin
                            r_next.done = 1'b1;
                            r_next.abort = 1'b1;
                        end
                    endcase
                end
            end
            DSP_XFER: begin
                if (i_data_valid) begin
                    r_next.wcnt = r_reg.wcnt + 8'h01;
                    if (r_reg.wcnt == WORD_CTL) begin
                        r_next.ctl_ident = i_data_word[CTL_IDENT_BIT];
                        r_next.ctl_level = i_data_word[CTL_LEVEL_BIT];
                    end
                    if (in_pw) begin
                        pw.wr = (r_reg.opcode == CMD_SET_PW);
                        pw.cmp = (r_reg.opcode == CMD_UNLOCK);
                    end
                    if (r_reg.wcnt == WORD_REV && r_reg.ctl_ident) begin
                        r_next.rev_in = i_data_word;
                    end
                    if (r_reg.wcnt == WORD_LAST) begin
                        r_next.state = DSP_EVAL;
                    end
                end
            end
            DSP_EVAL: begin
                r_next.state = DSP_IDLE;
                r_next.done = 1'b1;
                if (r_reg.opcode == CMD_SET_PW) begin
                    if (r_reg.ctl_ident) begin
                        r_next.rev = r_reg.rev_in;
                    end else begin
                        r_next.enabled = 1'b1;
                        r_next.level = r_reg.ctl_level;
                    end
                end else if (r_reg.ctl_ident && r_reg.level == LEVEL_MAX) begin
                    r_next.abort = 1'b1;
                end else if (pw.match) begin
                    r_next.locked = 1'b0;
                end else begin
                    r_next.abort = 1'b1;
                    if (r_reg.locked) begin
                        r_next.cnt = r_reg.cnt - 3'h1;
                    end
                end
            end
            default: begin
                r_next.state = DSP_IDLE;
            end
        endcase
        // ****************************************
        // register writes and hard reset
        // ****************************************
        if (hrst) begin
            r_next.cnt = UNLOCK_TRIES;
            r_next.frozen = 1'b0;
            r_next.locked = r_reg.enabled;
            r_next.prep = 1'b0;
        end
        if (freeze) begin
            r_next.frozen = 1'b1;
        end
        if (apb_access && i_pwrite && i_paddr == OFS_IRQ_MASK) begin
            r_next.irq_mask = i_pwdata[IRQ_W-1:0];
        end
        if (apb_setup) begin
            case (i_paddr)
                OFS_STATE: begin
                    r_next.prdata = '0;
                    r_next.prdata[ST_ENABLED_BIT] = r_reg.enabled;
                    r_next.prdata[ST_LOCKED_BIT] = r_reg.locked;
                    r_next.prdata[ST_FROZEN_BIT] = r_reg.frozen;
                    r_next.prdata[ST_LEVEL_BIT] = r_reg.level;
                    r_next.prdata[ST_PREP_BIT] = r_reg.prep;
                    r_next.prdata[ST_CNT_LSB +: 3] = r_reg.cnt;
                end
                OFS_REV: r_next.prdata = {16'h0000, r_reg.rev};
                OFS_IRQ_STAT: r_next.prdata = {29'h0, r_reg.irq_stat};
                OFS_IRQ_MASK: r_next.prdata = {29'h0, r_reg.irq_mask};
                default: r_next.prdata = '0;
            endcase
        end
        // events: ok, aborted, counter exhausted; set wins over clear
        ev[0] = r_next.done && !r_next.abort;
        ev[1] = r_next.abort;
        ev[2] = (r_reg.cnt != '0) && (r_next.cnt == '0);
        r_next.irq_stat = (r_reg.irq_stat & ~clr) | ev;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            r_reg <= '0;
            r_reg.state <= DSP_IDLE;
            r_reg.cnt <= UNLOCK_TRIES;
            r_reg.rev <= REV_RESET;
            r_reg.level <= LEVEL_HIGH;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_prdata = r_reg.prdata;
    assign o_pready = 1'b1;
    assign o_pslverr = apb_access && !apb_hit;
    assign o_cmd_ready = (r_reg.state == DSP_IDLE);
    assign o_data_ready = (r_reg.state == DSP_XFER);
    assign o_done = r_reg.done;
    assign o_abort = r_reg.abort;
    assign o_erase_grant = r_reg.grant;
    assign o_locked = r_reg.locked;
    assign o_id_word92 = r_reg.rev;
    assign o_taskfile_we = 1'b0;
    assign o_irq = |(r_reg.irq_stat & r_reg.irq_mask);

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);

    a_frozen_rejects: assert property (
        o_cmd_ready && i_cmd_valid && r_reg.frozen && !hrst
        |=> o_done && o_abort && !o_erase_grant) else $error("frozen command not rejected");
    a_cnt_zero_abort: assert property (
        o_cmd_ready && i_cmd_valid && r_reg.cnt == '0 && !hrst
        && (i_cmd_code == CMD_UNLOCK || i_cmd_code == CMD_ERASE_UNIT)
        |=> o_abort && o_cmd_ready) else $error("exhausted counter did not abort");
    a_erase_needs_prep: assert property (
        o_cmd_ready && i_cmd_valid && i_cmd_code == CMD_ERASE_UNIT && !r_reg.prep
        |=> o_done && o_abort) else $error("erase unit without prepare");
    a_set_requests: assert property (
        o_cmd_ready && i_cmd_valid && i_cmd_code == CMD_SET_PW && !r_reg.frozen
        |=> o_data_ready ##0 !o_cmd_ready) else $error("set password asked no sector");
    a_unlocked_cnt: assert property (
        r_reg.state == DSP_EVAL && r_reg.opcode == CMD_UNLOCK && !r_reg.locked && !hrst
        |=> $stable(r_reg.cnt)) else $error("counter moved while unlocked");
    a_mismatch_dec: assert property (
        r_reg.state == DSP_EVAL && r_reg.opcode == CMD_UNLOCK && r_reg.locked && !hrst
        && !r_reg.ctl_ident && !pw.match
        |=> o_abort && r_reg.cnt == $past(r_reg.cnt) - 3'h1) else $error("mismatch not counted");
    a_master_max_rej: assert property (
        r_reg.state == DSP_EVAL && r_reg.opcode == CMD_UNLOCK && r_reg.ctl_ident
        && r_reg.level == LEVEL_MAX && !hrst
        |=> o_abort && $stable(r_reg.locked)) else $error("master unlock at maximum");
    a_master_keeps: assert property (
        r_reg.state == DSP_EVAL && r_reg.opcode == CMD_SET_PW && r_reg.ctl_ident
        |=> $stable(r_reg.level) && $stable(r_reg.enabled)
        && o_id_word92 == $past(r_reg.rev_in)) else $error("master set changed level");
    a_user_arms: assert property (
        r_reg.state == DSP_EVAL && r_reg.opcode == CMD_SET_PW && !r_reg.ctl_ident
        |=> r_reg.enabled && r_reg.level == $past(r_reg.ctl_level))
        else $error("user set not armed");
    a_hrst_restores: assert property (
        hrst && !freeze |=> r_reg.cnt == UNLOCK_TRIES && !r_reg.frozen)
        else $error("hard reset not restoring");
    a_sector_length: assert property (
        r_reg.state == DSP_XFER && r_reg.wcnt == WORD_LAST && i_data_valid
        |=> r_reg.state == DSP_EVAL ##1 o_done) else $error("sector length wrong");
endmodule
`default_nettype wire

// ### rtl/dsp_pkg.sv
/*
 * Constants, command codes, register map and state type of the drive
 * security password block. Assumes a single 100 MHz clock domain.
 */
// Functional notes
// - set-password requests one sector from host
// - words 1-16 password, 17 revision if master
// - accept revision codes, report in identify word 92
// - control bit 8 level, bit 0 identifier
// - user/high: store, arm lock, both unlock
// - user/maximum: store, arm lock, only user unlocks
// - master: store with revision, level unchanged, no arming
// - unlock requests sector, bit 0 selects password
// - master unlock at high level compares master
// - master unlock at maximum level is rejected
// - user mismatch aborts and decrements counter
// - counter starts at five, decrements when locked
// - counter zero aborts unlock and erase-unit
// - unlock while unlocked leaves counter alone
// - erase-unit aborted without preceding erase-prepare
// - frozen rejects all lock-changing security commands
package dsp_pkg;
    // ****************************************
    // command codes
    // ****************************************
    localparam logic [7:0] CMD_SET_PW = 8'hF1;
    localparam logic [7:0] CMD_UNLOCK = 8'hF2;
    localparam logic [7:0] CMD_ERASE_PREP = 8'hF3;
    localparam logic [7:0] CMD_ERASE_UNIT = 8'hF4;
    localparam logic [7:0] CMD_DISABLE_PW = 8'hF6;
    // ****************************************
    // data sector layout
    // ****************************************
    localparam logic [7:0] WORD_CTL = 8'h00;
    localparam logic [7:0] WORD_PW_FIRST = 8'h01;
    localparam logic [7:0] WORD_PW_LAST = 8'h10;
    localparam logic [7:0] WORD_REV = 8'h11;
    localparam logic [7:0] WORD_LAST = 8'hFF;
    localparam int CTL_IDENT_BIT = 0;
    localparam int CTL_LEVEL_BIT = 8;
    localparam logic LEVEL_HIGH = 1'b0;
    localparam logic LEVEL_MAX = 1'b1;
    localparam logic [2:0] UNLOCK_TRIES = 3'h5;
    localparam logic [15:0] REV_RESET = 16'h0000;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATE = 8'h04;
    localparam logic [7:0] OFS_REV = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam int CTRL_HRST_BIT = 0;
    localparam int CTRL_FREEZE_BIT = 1;
    localparam int ST_ENABLED_BIT = 0;
    localparam int ST_LOCKED_BIT = 1;
    localparam int ST_FROZEN_BIT = 2;
    localparam int ST_LEVEL_BIT = 3;
    localparam int ST_PREP_BIT = 4;
    localparam int ST_CNT_LSB = 8;
    localparam int IRQ_W = 3;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // ****************************************
    // command sequencer states
    // ****************************************
    typedef enum logic [1:0] {
        DSP_IDLE = 2'h0,
        DSP_XFER = 2'h1,
        DSP_EVAL = 2'h3
    } dsp_state_t;
endpackage

// ### rtl/dsp_pw_if.sv
/*
 * Interface between the command sequencer and the password store.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface dsp_pw_if;
    logic start;
    logic wr;
    logic cmp;
    logic sel_master;
    logic [3:0] idx;
    logic [15:0] word;
    logic match;
    modport ctl (output start, wr, cmp, sel_master, idx, word, input match);
    modport store (input start, wr, cmp, sel_master, idx, word, output match);
endinterface
`default_nettype wire

// ### rtl/dsp_pw_store.sv
/*
 * Password store: user and master passwords, 16 words each, written
 * or compared one word at a time. Assumes idx counts words 0 to 15.
 */
`timescale 1ns/100ps
`default_nettype none
module dsp_pw_store
    import dsp_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    dsp_pw_if.store pw
);
    typedef struct packed {
        logic [15:0][15:0] user_pw;
        logic [15:0][15:0] master_pw;
        logic mismatch;
    } dsp_store_t;

    dsp_store_t r_reg;
    dsp_store_t r_next;

    always_comb begin
        r_next = r_reg;
        if (pw.start) begin
            r_next.mismatch = 1'b0;
        end
        if (pw.wr) begin
            if (pw.sel_master) begin
                r_next.master_pw[pw.idx] = pw.word;
            end else begin
                r_next.user_pw[pw.idx] = pw.word;
            end
        end
        if (pw.cmp) begin
            if (pw.word != (pw.sel_master ? r_reg.master_pw[pw.idx] : r_reg.user_pw[pw.idx])) begin
                r_next.mismatch = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign pw.match = ~r_reg.mismatch;

    a_start_clears: assert property (@(posedge i_core_clk) disable iff (i_reset)
        pw.start && !pw.cmp |=> pw.match) else $error("compare not cleared by start");
endmodule
`default_nettype wire

// ### verif/dsp_host_model.sv
/*
 * Host model: offers one security command and, when the block asks for
 * it, a 256-word sector. Assumes the block handshakes on the rising edge.
 */
`timescale 1ns/100ps
`default_nettype none
module dsp_host_model (
    input wire logic i_core_clk,
    input wire logic i_cmd_ready,
    input wire logic i_data_ready,
    input wire logic i_done,
    input wire logic i_abort,
    input wire logic i_erase_grant,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_code,
    output logic o_data_valid,
    output logic [15:0] o_data_word
);
    logic abort_seen;
    logic grant_seen;
    int lat;
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_code = 8'h00;
        o_data_valid = 1'b0;
        o_data_word = 16'hFFFF;
    end
    // ****************************************
    // command, optional sector, completion
    // ****************************************
    task automatic issue(input logic [7:0] code, input logic [15:0] ctl,
        input logic [15:0] pw, input logic [15:0] rev, input bit slow);
        logic [15:0] d;
        @(posedge i_core_clk);
        o_cmd_code <= code;
        o_cmd_valid <= 1'b1;
        do @(posedge i_core_clk); while (i_cmd_ready !== 1'b1);
        o_cmd_valid <= 1'b0;
        o_cmd_code <= ~code;
        lat = 0;
        do begin
            @(posedge i_core_clk);
            lat++;
            if (i_data_ready === 1'b1) begin
                for (int w = 0; w < 256; w++) begin
                    // reserved words vary so a decoder that reads them shows
                    d = (w == 0) ? ctl : (w <= 16) ? pw ^ 16'(w)
                        : (w == 17) ? rev : ~16'(w);
                    o_data_valid <= 1'b1;
                    o_data_word <= d;
                    do @(posedge i_core_clk); while (i_data_ready !== 1'b1);
                    if (slow || w == 255) begin
                        o_data_valid <= 1'b0;
                        o_data_word <= ~d;
                    end
                    if (slow && w != 255) @(posedge i_core_clk);
                end
                lat = 0;
            end
        end while (i_done !== 1'b1 && lat < 20);
        abort_seen = i_abort;
        grant_seen = i_erase_grant;
    endtask
endmodule
`default_nettype wire

// ### verif/dsp_sec_top_test.sv
/*
 * Self-checking bench of the security password block: APB registers,
 * host commands with sectors, lock state, unlock counter, erase order.
 * Assumes the host model is compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module dsp_sec_top_test
    import dsp_pkg::*;
();
    localparam logic [7:0] OFS_NONE = 8'h14;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr, cmd_valid, cmd_ready, data_valid, data_ready;
    logic done, abort, grant, locked, tf_we, irq;
    logic [7:0] cmd_code;
    logic [15:0] data_word, id92;
    logic [7:0] frz[5] = '{CMD_SET_PW, CMD_UNLOCK, CMD_ERASE_PREP, CMD_ERASE_UNIT, CMD_DISABLE_PW};
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    dsp_sec_top dsp_sec_top_i (.i_core_clk(clk), .i_reset(rst), .i_paddr(paddr), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code),
        .o_cmd_ready(cmd_ready), .i_data_valid(data_valid), .i_data_word(data_word),
        .o_data_ready(data_ready), .o_done(done), .o_abort(abort), .o_erase_grant(grant),
        .o_locked(locked), .o_id_word92(id92), .o_taskfile_we(tf_we), .o_irq(irq));
    dsp_host_model dsp_host_model_i (.i_core_clk(clk), .i_cmd_ready(cmd_ready),
        .i_data_ready(data_ready), .i_done(done), .i_abort(abort), .i_erase_grant(grant),
        .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code), .o_data_valid(data_valid),
        .o_data_word(data_word));
    always #5 clk = ~clk;
    // ****************************************
    // compares, bus cycles, commands
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk("read data", exp, rdata);
    endtask
    task automatic st(input logic [31:0] exp);
        rd(OFS_STATE, exp);
    endtask
    task automatic irqc(input logic exp);
        @(negedge clk);
        chk1("irq", exp, irq);
    endtask
    function automatic logic [31:0] sv(input logic en, lk, fr, lv, pr, input logic [2:0] cnt);
        return {21'h000000, cnt, 3'h0, pr, lv, fr, lk, en};
    endfunction
    task automatic cmd(input logic [7:0] code, input logic ab, input logic sec,
        input logic [15:0] ctl = 16'h0000, input logic [15:0] pw = 16'h0000,
        input logic [15:0] rev = 16'h0000, input bit slow = 1'b0);
        dsp_host_model_i.issue(code, ctl, pw, rev, slow);
        chk1("abort", ab, dsp_host_model_i.abort_seen);
        chk("latency", sec ? 32'h2 : 32'h1, dsp_host_model_i.lat);
        chk1("taskfile write", 1'b0, tf_we);
    endtask
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        st(sv(0, 0, 0, 0, 0, 3'h5));
        rd(OFS_CTRL, 32'h00000000);
        rd(OFS_NONE, 32'h00000000);
        chk1("slverr", 1'b1, rerr);
        apb(1'b1, OFS_IRQ_MASK, 32'h00000007);
        rd(OFS_IRQ_MASK, 32'h00000007);
        cmd(CMD_SET_PW, 1'b0, 1'b1, 16'hFEFF, 16'h1000, 16'h0001);
        chk("word92", 32'h00000001, {16'h0000, id92});
        st(sv(0, 0, 0, 0, 0, 3'h5));
        cmd(CMD_SET_PW, 1'b0, 1'b1, 16'h0000, 16'h2000, 16'h1234, 1'b1);
        st(sv(1, 0, 0, 0, 0, 3'h5));
        rd(OFS_REV, 32'h00000001);
        irqc(1'b1);
        rd(OFS_IRQ_STAT, 32'h00000001);
        irqc(1'b0);
        apb(1'b1, OFS_CTRL, 32'h00000001);
        st(sv(1, 1, 0, 0, 0, 3'h5));
        chk1("locked", 1'b1, locked);
        cmd(CMD_UNLOCK, 1'b1, 1'b1, 16'h0000, 16'h2001);
        st(sv(1, 1, 0, 0, 0, 3'h4));
        cmd(CMD_UNLOCK, 1'b0, 1'b1, 16'h0001, 16'h1000, 16'h0000, 1'b1);
        st(sv(1, 0, 0, 0, 0, 3'h4));
        chk1("locked", 1'b0, locked);
        cmd(CMD_UNLOCK, 1'b1, 1'b1, 16'h0000, 16'h2001);
        st(sv(1, 0, 0, 0, 0, 3'h4));
        cmd(CMD_SET_PW, 1'b0, 1'b1, 16'h0101, 16'h1000, 16'hFFFE);
        chk("word92", 32'h0000FFFE, {16'h0000, id92});
        cmd(CMD_SET_PW, 1'b0, 1'b1, 16'h0100, 16'h3000);
        st(sv(1, 0, 0, 1, 0, 3'h4));
        apb(1'b1, OFS_CTRL, 32'h00000001);
        cmd(CMD_UNLOCK, 1'b1, 1'b1, 16'h0001, 16'h1000);
        st(sv(1, 1, 0, 1, 0, 3'h5));
        apb(1'b1, OFS_IRQ_MASK, 32'h00000000);
        repeat (5) cmd(CMD_UNLOCK, 1'b1, 1'b1, 16'h0000, 16'h2001);
        irqc(1'b0);
        st(sv(1, 1, 0, 1, 0, 3'h0));
        apb(1'b1, OFS_IRQ_MASK, 32'h00000007);
        irqc(1'b1);
        rd(OFS_IRQ_STAT, 32'h00000007);
        irqc(1'b0);
        cmd(CMD_UNLOCK, 1'b1, 1'b0, 16'h0000, 16'h3000);
        cmd(CMD_ERASE_PREP, 1'b0, 1'b0);
        cmd(CMD_ERASE_UNIT, 1'b1, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h00000001);
        st(sv(1, 1, 0, 1, 0, 3'h5));
        cmd(CMD_UNLOCK, 1'b0, 1'b1, 16'h0000, 16'h3000);
        cmd(CMD_ERASE_UNIT, 1'b1, 1'b0);
        cmd(CMD_ERASE_PREP, 1'b0, 1'b0);
        st(sv(1, 0, 0, 1, 1, 3'h5));
        cmd(CMD_ERASE_UNIT, 1'b0, 1'b0);
        chk1("grant", 1'b1, dsp_host_model_i.grant_seen);
        cmd(CMD_ERASE_PREP, 1'b0, 1'b0);
        cmd(CMD_UNLOCK, 1'b0, 1'b1, 16'h0000, 16'h3000);
        cmd(CMD_ERASE_UNIT, 1'b1, 1'b0);
        chk1("grant", 1'b0, dsp_host_model_i.grant_seen);
        apb(1'b1, OFS_CTRL, 32'h00000002);
        st(sv(1, 0, 1, 1, 0, 3'h5));
        foreach (frz[k]) cmd(frz[k], 1'b1, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h00000001);
        cmd(CMD_ERASE_PREP, 1'b0, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
